// ===== core/acs_pkg.sv
// shared constants for the converter control block
package acs_pkg;
   localparam int DATA_W = 24;
   localparam int PIN_W = 8;
   localparam logic [23:0] CODE_POS_CLIP = 24'h7f_ffff;
   localparam logic [23:0] CODE_NEG_CLIP = 24'h80_0000;
   localparam logic [23:0] CODE_POS_REF = 24'h78_0000;
   localparam logic [23:0] CODE_NEG_REF = 24'h87_ffff;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam logic CLK_OUT_EN_RESET = 1'b1;
   localparam int CLK_MHZ = 100;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   localparam int PIN_LOW_CYCLES = 2;
   localparam int WAKE_PIN_CYCLES = 2;
   localparam int WAKE_POR_CYCLES = 262144;
   localparam int OSC_START_NS = 1000;
   localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYCLES = 64;
   localparam int UV_TRIP_MV = 4300;
   localparam int UV_HYST_MV = 50;
   localparam int SUPPLY_W = 13;
endpackage : acs_pkg

// ===== core/acs_sync.sv
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module acs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= INIT;
         q <= INIT;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : acs_sync

// ===== core/acs_ctrl.sv
// control, status, pin port and result path of the converter
`timescale 1ns/1ps
// What this block does
// - chop pairs swapped-polarity conversions and averages
// - chop halves the result rate
// - eight pins each with own direction bit
// - level read shows pins, write sets latch
// - pins keep working in idle and power-down
// - reset makes all pins inputs
// - power-down after two low clock samples when running, after one low sample during wake
// - registers kept through power-down
// - external clock wake 2 or 2^18 cycles
// - oscillator wake adds start-up to that interval
// - power-on reset restores defaults like reset pin, then reruns the power-on wake
// - reset pin low two cycles restores defaults
// - select pin picks oscillator or clock pin
// - clock pin driven only when enable set
// - start runs conversions, stop finishes current one
// - ready low on result, high at first read edge
// - unread ready pulses high on next result
// - new-data flag set on new channel data
// - two's complement result clipped, never wrapped
// - undervoltage zeroes supply reading, sets flag
module acs_ctrl #(
   parameter int WAKE_POR = acs_pkg::WAKE_POR_CYCLES,
   parameter int CONV = acs_pkg::CONV_CYCLES
) (
   // clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   // control pins
   input wire logic power_down_n,
   input wire logic reset_n,
   input wire logic start,
   input wire logic clock_source_select,
   input wire logic power_on,
   // configuration
   input wire logic chop_en,
   input wire logic clock_out_enable,
   input wire logic [7:0] pin_direction_reg,
   input wire logic [7:0] pin_level_wdata,
   input wire logic pin_level_we,
   input wire logic cfg_we,
   // modulator and supply inputs
   input wire logic [24:0] raw_sample,
   input wire logic [12:0] supply_mv,
   // serial read on link clock
   input wire logic read_frame,
   // general-purpose pins
   input wire logic [7:0] gp_in,
   output logic [7:0] gp_out,
   output logic [7:0] gp_oe,
   output logic [7:0] pin_level_reg,
   // clock pin and status
   output logic clock_pin_oe,
   output logic ready,
   output logic powered_down,
   output logic converting,
   output logic data_ready_n,
   output logic new_data,
   output logic supply_low,
   output logic [23:0] result,
   output logic [23:0] supply_result,
   output logic chop_eff,
   output logic clk_out_en_reg,
   output logic [7:0] dir_reg
);
   typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_PHASE2} acs_cv_t;
   typedef enum logic [1:0] {ACS_OFF, ACS_WAKE, ACS_RUN} acs_pw_t;

   logic [4:0] syn;
   logic pd_s, rs_s, st_s, cs_s, po_s;
   logic pd_q, rs_q;
   logic soft_rst;
   logic [7:0] gp_s;
   logic [7:0] level_latch;
   acs_pw_t pw;
   acs_cv_t cv;
   logic [18:0] wake_cnt;
   logic por_pending;
   logic [15:0] conv_cnt;
   logic [24:0] first_half;
   logic [25:0] sum;
   logic [24:0] avg;
   logic [23:0] clipped;
   logic done;
   logic rd_tog_l, rd_tog_s, rd_seen;
   logic frame_clr, in_frame;
   logic rd_pend;
   logic pulse_hi;

   // control pins cross from the outside world
   acs_sync #(.W(5), .INIT(5'b1_1000)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({power_down_n, reset_n, start, clock_source_select, power_on}),
      .q(syn)
   );
   assign {pd_s, rs_s, st_s, cs_s, po_s} = syn;

   // general-purpose pin inputs cross too
   acs_sync #(.W(8), .INIT(8'h00)) u_gp_sync (
      .clk(clk),
      .rst(rst),
      .d(gp_in),
      .q(gp_s)
   );

   // previous samples for the two-low check
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pd_q <= 1'b1;
         rs_q <= 1'b1;
      end
      else
      begin
         pd_q <= pd_s;
         rs_q <= rs_s;
      end
   end

   // reset pin or power-on pulse restore defaults the same way
   assign soft_rst = (!rs_s && !rs_q) || po_s;

   // configuration registers, kept through power-down
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dir_reg <= acs_pkg::DIR_RESET;
         clk_out_en_reg <= acs_pkg::CLK_OUT_EN_RESET;
         chop_eff <= 1'b0;
      end
      else if (soft_rst)
      begin
         dir_reg <= acs_pkg::DIR_RESET;
         clk_out_en_reg <= acs_pkg::CLK_OUT_EN_RESET;
         chop_eff <= 1'b0;
      end
      else if (cfg_we)
      begin
         dir_reg <= pin_direction_reg;
         clk_out_en_reg <= clock_out_enable;
         chop_eff <= chop_en;
      end
   end

   // output latch of the pin port
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         level_latch <= acs_pkg::LEVEL_RESET;
      else if (soft_rst)
         level_latch <= acs_pkg::LEVEL_RESET;
      else if (pin_level_we)
         level_latch <= pin_level_wdata;
   end

   // pin drive and readback, active in every power state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gp_out <= acs_pkg::LEVEL_RESET;
         gp_oe <= acs_pkg::DIR_RESET;
         pin_level_reg <= 8'h00;
      end
      else
      begin
         gp_out <= level_latch;
         gp_oe <= dir_reg;
         pin_level_reg <= (gp_s & ~gp_oe) | (gp_out & gp_oe);
      end
   end

   // power state and wake timing
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pw <= ACS_WAKE;
         wake_cnt <= '0;
         por_pending <= 1'b1;
      end
      else if (soft_rst && po_s)
      begin
         pw <= ACS_WAKE;
         wake_cnt <= '0;
         por_pending <= 1'b1;
      end
      else
      begin
         unique case (pw)
            ACS_RUN:
               if (!pd_s && !pd_q)
                  pw <= ACS_OFF;
            ACS_OFF:
               if (pd_s)
               begin
                  pw <= ACS_WAKE;
                  wake_cnt <= '0;
               end
            ACS_WAKE:
            begin
               wake_cnt <= wake_cnt + 19'd1;
               if (!pd_s)
                  pw <= ACS_OFF;
               else if (wake_cnt + 19'd1 >= 19'(
                  (cs_s ? 0 : acs_pkg::OSC_START_CYCLES)
                  + (por_pending ? WAKE_POR : acs_pkg::WAKE_PIN_CYCLES)))
               begin
                  pw <= ACS_RUN;
                  por_pending <= 1'b0;
               end
            end
         endcase
      end
   end

   // power status outputs and clock pin drive
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ready <= 1'b0;
         powered_down <= 1'b0;
         clock_pin_oe <= 1'b0;
      end
      else
      begin
         ready <= (pw == ACS_RUN);
         powered_down <= (pw == ACS_OFF);
         clock_pin_oe <= !cs_s && clk_out_en_reg && (pw == ACS_RUN);
      end
   end

   // conversion sequencing with optional chop pair
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cv <= ACS_IDLE;
         conv_cnt <= '0;
         first_half <= '0;
      end
      else if (soft_rst || pw != ACS_RUN)
      begin
         cv <= ACS_IDLE;
         conv_cnt <= '0;
      end
      else
      begin
         unique case (cv)
            ACS_IDLE:
               if (st_s)
               begin
                  cv <= ACS_CONV;
                  conv_cnt <= '0;
               end
            ACS_CONV:
            begin
               conv_cnt <= conv_cnt + 16'd1;
               if (conv_cnt == 16'(CONV - 1))
               begin
                  conv_cnt <= '0;
                  if (chop_eff)
                  begin
                     first_half <= raw_sample;
                     cv <= ACS_PHASE2;
                  end
                  else if (!st_s)
                     cv <= ACS_IDLE;
               end
            end
            ACS_PHASE2:
            begin
               conv_cnt <= conv_cnt + 16'd1;
               if (conv_cnt == 16'(CONV - 1))
               begin
                  conv_cnt <= '0;
                  cv <= st_s ? ACS_CONV : ACS_IDLE;
               end
            end
            default:
               cv <= ACS_IDLE;
         endcase
      end
   end

   // second phase sees swapped polarity, so negate before averaging
   assign sum = chop_eff ? ({first_half[24], first_half} - {raw_sample[24], raw_sample})
      : {raw_sample[24], raw_sample};
   assign avg = chop_eff ? sum[25:1] : sum[24:0];
   assign clipped = (avg > 25'sh07f_ffff && !avg[24]) ? acs_pkg::CODE_POS_CLIP
      : (avg[24] && avg < 25'h180_0000) ? acs_pkg::CODE_NEG_CLIP
      : avg[23:0];
   assign done = (conv_cnt == 16'(CONV - 1))
      && ((cv == ACS_CONV && !chop_eff) || cv == ACS_PHASE2);

   // frame end clears the marker even though sclk stands still then
   assign frame_clr = rst || !read_frame;

   // marks that the first falling edge of this frame has passed
   always_ff @(negedge sclk or posedge frame_clr)
   begin
      if (frame_clr)
         in_frame <= 1'b0;
      else
         in_frame <= 1'b1;
   end

   // read frames cross from the link clock as a toggle, once per frame
   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
         rd_tog_l <= 1'b0;
      else if (read_frame && !in_frame)
         rd_tog_l <= ~rd_tog_l;
   end

   acs_sync #(.W(1), .INIT(1'b0)) u_rd_sync (
      .clk(clk),
      .rst(rst),
      .d(rd_tog_l),
      .q(rd_tog_s)
   );

   // edge of the synchronised toggle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_seen <= 1'b0;
      else
         rd_seen <= rd_tog_s;
   end
   assign rd_pend = rd_seen ^ rd_tog_s;

   // result, ready pin and new-data flag; a new result wins over a read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         result <= '0;
         data_ready_n <= 1'b1;
         new_data <= 1'b0;
         pulse_hi <= 1'b0;
         converting <= 1'b0;
      end
      else if (soft_rst)
      begin
         result <= '0;
         data_ready_n <= 1'b1;
         new_data <= 1'b0;
         pulse_hi <= 1'b0;
         converting <= 1'b0;
      end
      else
      begin
         converting <= (cv != ACS_IDLE);
         pulse_hi <= 1'b0;
         if (done)
         begin
            result <= clipped;
            new_data <= 1'b1;
            if (!data_ready_n)
            begin
               data_ready_n <= 1'b1;
               pulse_hi <= 1'b1;
            end
            else
               data_ready_n <= 1'b0;
         end
         else if (pulse_hi)
            data_ready_n <= 1'b0;
         else if (rd_pend)
         begin
            data_ready_n <= 1'b1;
            new_data <= 1'b0;
         end
      end
   end

   // supply monitor with trip and hysteresis
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         supply_low <= 1'b0;
         supply_result <= '0;
      end
      else
      begin
         if (supply_mv < 13'(acs_pkg::UV_TRIP_MV))
            supply_low <= 1'b1;
         else if (supply_mv >= 13'(acs_pkg::UV_TRIP_MV + acs_pkg::UV_HYST_MV))
            supply_low <= 1'b0;
         supply_result <= (supply_mv < 13'(acs_pkg::UV_TRIP_MV)) ? 24'h00_0000
            : {11'h000, supply_mv};
      end
   end

   // checks
   pd_enter_a: assert property (@(posedge clk) disable iff (rst)
      (pw == ACS_RUN && !pd_s && !pd_q && !(soft_rst && po_s)) |=> pw == ACS_OFF)
      else $error("power-down not entered");
   pin_dir_a: assert property (@(posedge clk) disable iff (rst)
      $past(soft_rst) |-> dir_reg == 8'h00)
      else $error("pins not inputs after reset");
   clk_oe_a: assert property (@(posedge clk) disable iff (rst)
      clock_pin_oe |-> $past(clk_out_en_reg) && !$past(cs_s))
      else $error("clock pin driven while disabled");
   data_ready_n_low_a: assert property (@(posedge clk) disable iff (rst)
      (done && data_ready_n && !soft_rst) |=> !data_ready_n && new_data)
      else $error("ready not asserted on result");
   data_ready_n_pulse_a: assert property (@(posedge clk) disable iff (rst)
      (done && !data_ready_n && !soft_rst) |=> data_ready_n ##1 !data_ready_n)
      else $error("ready pulse missing");
   clip_a: assert property (@(posedge clk) disable iff (rst)
      (done && !soft_rst && !avg[24] && avg[23]) |=> result == 24'h7f_ffff)
      else $error("positive result wrapped");
   uv_a: assert property (@(posedge clk) disable iff (rst)
      supply_mv < 13'd4300 |=> supply_low && supply_result == 24'h00_0000)
      else $error("undervoltage not flagged");
   gp_lvl_a: assert property (@(posedge clk) disable iff (rst)
      pin_level_we && !soft_rst |=> ##1 gp_out == $past(pin_level_wdata, 2))
      else $error("pin latch not written");
   wake_a: assert property (@(posedge clk) disable iff (rst)
      (pw == ACS_OFF && pd_s && cs_s && !por_pending && !soft_rst) |=> ##2
      (pw == ACS_RUN || !pd_s))
      else $error("wake time wrong");
endmodule : acs_ctrl

// ===== tb/acs_host.sv
// host serial port model: read frames on the link clock
`timescale 1ns/1ps
module acs_host (
   // request from the bench
   input wire logic go,
   // serial port
   output logic sclk,
   output logic read_frame
);
   // sclk stands low outside frames, 12 ns period inside one
   initial
   begin
      sclk = 1'h0;
      read_frame = 1'h0;
      forever
      begin
         @(posedge go);
         #3.7 read_frame = 1'h1;
         repeat (8)
         begin
            #6 sclk = 1'h1;
            #6 sclk = 1'h0;
         end
         #6 read_frame = 1'h0;
      end
   end
endmodule : acs_host

// ===== tb/tb_adc_control_pins_and_status.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_adc_control_pins_and_status;
   // pins and configuration driven by the bench
   logic clk, rst, start, clock_source_select, go, chop_en, clock_out_enable;
   logic pin_level_we, cfg_we, sclk, read_frame;
   logic [2:0] lo;
   logic [7:0] pin_direction_reg, pin_level_wdata, ext;
   logic [24:0] raw_sample;
   logic [12:0] supply_mv;
   // outputs of the block
   logic clock_pin_oe, ready, powered_down, converting, data_ready_n, new_data;
   logic supply_low, chop_eff, clk_out_en_reg;
   logic [7:0] gp_out, gp_oe, pin_level_reg, dir_reg;
   logic [23:0] result, supply_result;
   wire logic [7:0] pins;
   wire logic power_down_n = ~lo[0];
   wire logic reset_n = ~lo[1];
   wire logic power_on = lo[2];
   int err_count, num_checks, n1;
   // pin wires: the block drives where enabled, the board elsewhere
   assign pins = (gp_oe & gp_out) | (~gp_oe & ext);

   acs_ctrl #(.WAKE_POR(16), .CONV(32)) DUT (
      .clk, .rst, .sclk, .power_down_n, .reset_n, .start, .clock_source_select, .power_on,
      .chop_en, .clock_out_enable, .pin_direction_reg, .pin_level_wdata, .pin_level_we,
      .cfg_we, .raw_sample, .supply_mv, .read_frame, .gp_in(pins), .gp_out, .gp_oe,
      .pin_level_reg, .clock_pin_oe, .ready, .powered_down, .converting, .data_ready_n,
      .new_data, .supply_low, .result, .supply_result, .chop_eff, .clk_out_en_reg, .dir_reg
   );
   acs_host host (.go, .sclk, .read_frame);

   // system clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // compare and count
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   // bounded wait for a level, sampled at the falling edge
   task automatic wait_lvl(ref logic s, input logic v, input int n, output int c);
      c = 0;
      while (s !== v)
      begin
         @(negedge clk);
         c++;
         if (c > n)
         begin
            chk("wait", 24'(v), 24'(s));
            finish_test();
         end
      end
   endtask : wait_lvl

   // one configuration write
   task automatic cfg(input logic ch, input logic ce, input logic [7:0] dir);
      @(posedge clk);
      chop_en <= ch;
      clock_out_enable <= ce;
      pin_direction_reg <= dir;
      cfg_we <= 1'h1;
      @(posedge clk);
      cfg_we <= 1'h0;
      tick(3);
   endtask : cfg

   // hold one control pin active for n cycles
   task automatic hold(input int k, input int n);
      @(posedge clk);
      lo[k] <= 1'h1;
      repeat (n) @(posedge clk);
      lo[k] <= 1'h0;
      tick(4);
   endtask : hold

   // defaults, wake-up and clock pin drive
   task automatic t_boot();
      int c;
      chk("dir", 24'h00, dir_reg);
      chk("oe", 24'h00, gp_oe);
      chk("clk en", 24'h1, clk_out_en_reg);
      chk("data_ready_n", 24'h1, data_ready_n);
      wait_lvl(ready, 1'h1, 400, c);
      chk("clk pin", 24'h1, clock_pin_oe);
      cfg(1'h0, 1'h0, 8'h00);
      chk("clk pin", 24'h0, clock_pin_oe);
      cfg(1'h0, 1'h1, 8'h00);
      @(posedge clk);
      clock_source_select <= 1'h1;
      tick(6);
      chk("clk pin", 24'h0, clock_pin_oe);
      wait_lvl(ready, 1'h1, 30, c);
   endtask : t_boot

   // direction and level of the general-purpose pins
   task automatic t_gpio();
      cfg(1'h0, 1'h1, 8'h0f);
      @(posedge clk);
      pin_level_wdata <= 8'h5a;
      pin_level_we <= 1'h1;
      @(posedge clk);
      pin_level_we <= 1'h0;
      tick(5);
      chk("oe", 24'h0f, gp_oe);
      chk("levels", 24'hca, pin_level_reg);
   endtask : t_gpio

   // short glitch ignored, power-down kept state, quick wake
   task automatic t_pdown();
      int c;
      hold(0, 1);
      chk("pd", 24'h0, powered_down);
      @(posedge clk);
      lo[0] <= 1'h1;
      wait_lvl(powered_down, 1'h1, 8, c);
      chk("oe", 24'h0f, gp_oe);
      chk("levels", 24'hca, pin_level_reg);
      @(posedge clk);
      lo[0] <= 1'h0;
      wait_lvl(ready, 1'h1, 12, c);
      chk("dir", 24'h0f, dir_reg);
   endtask : t_pdown

   // results, read handshake, unread pulses, clipping, stop
   task automatic t_conv();
      int c, d;
      logic [24:0] raw [4] = '{25'h0ff_ffff, 25'h100_0000, 25'h078_0000, 25'h187_ffff};
      logic [23:0] exp [4] = '{24'h7f_ffff, 24'h80_0000, 24'h78_0000, 24'h87_ffff};
      @(posedge clk);
      raw_sample <= 25'h000_1234;
      start <= 1'h1;
      wait_lvl(data_ready_n, 1'h0, 300, c);
      chk("result", 24'h00_1234, result);
      chk("new", 24'h1, new_data);
      go = 1'h1;
      tick(1);
      go = 1'h0;
      wait_lvl(data_ready_n, 1'h1, 12, c);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         raw_sample <= raw[i];
         if (i > 0)
            wait_lvl(data_ready_n, 1'h1, 60, c);
         wait_lvl(data_ready_n, 1'h0, (i > 0) ? 3 : 60, d);
         chk("clip", exp[i], result);
         n1 = c + d;
      end
      @(posedge clk);
      start <= 1'h0;
      wait_lvl(data_ready_n, 1'h1, 60, c);
      wait_lvl(converting, 1'h0, 12, c);
      tick(80);
      chk("idle", 24'h0, data_ready_n);
   endtask : t_conv

   // chopped pairs: offset cancels, half the rate
   task automatic t_chop();
      int c, d;
      cfg(1'h1, 1'h1, 8'h0f);
      chk("chop", 24'h1, chop_eff);
      @(posedge clk);
      raw_sample <= 25'h000_0100;
      start <= 1'h1;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         wait_lvl(data_ready_n, 1'h1, 300, c);
         wait_lvl(data_ready_n, 1'h0, 3, d);
      end
      chk("chop avg", 24'h0, result);
      chk("chop rate", 24'(2 * n1), 24'(c + d));
      @(posedge clk);
      start <= 1'h0;
      wait_lvl(converting, 1'h0, 150, c);
      cfg(1'h0, 1'h1, 8'h0f);
   endtask : t_chop

   // undervoltage trip and hysteresis
   task automatic t_supply();
      logic [12:0] mv [4] = '{13'h1388, 13'h10cb, 13'h10f4, 13'h1130};
      logic lowv [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         supply_mv <= mv[i];
         tick(6);
         chk("uv", 24'(lowv[i]), 24'(supply_low));
         if (mv[i] < 13'(acs_pkg::UV_TRIP_MV))
            chk("supply", 24'h0, supply_result);
         else
            chk("supply", {11'h000, mv[i]}, supply_result);
      end
   endtask : t_supply

   // soft reset and power-on reset
   task automatic t_reset();
      int c;
      hold(1, 1);
      chk("dir", 24'h0f, dir_reg);
      hold(1, 3);
      chk("dir", 24'h00, dir_reg);
      chk("oe", 24'h00, gp_oe);
      chk("data_ready_n", 24'h1, data_ready_n);
      cfg(1'h0, 1'h0, 8'hf0);
      hold(2, 3);
      chk("dir", 24'h00, dir_reg);
      chk("clk en", 24'h1, clk_out_en_reg);
      chk("ready", 24'h0, ready);
      wait_lvl(ready, 1'h1, 60, c);
   endtask : t_reset

   // main sequence
   initial
   begin
      rst = 1'h1;
      lo = 3'h0;
      go = 1'h0;
      start = 1'h0;
      clock_source_select = 1'h0;
      chop_en = 1'h0;
      clock_out_enable = 1'h1;
      pin_direction_reg = 8'h00;
      pin_level_wdata = 8'h00;
      pin_level_we = 1'h0;
      cfg_we = 1'h0;
      ext = 8'hc3;
      raw_sample = 25'h000_0000;
      supply_mv = 13'h1388;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      tick(1);
      t_boot();
      t_gpio();
      t_pdown();
      t_conv();
      t_chop();
      t_supply();
      t_reset();
      finish_test();
   end
endmodule : tb_adc_control_pins_and_status
